// File: logic/board_ctl_pkg.sv
// board_ctl_pkg: constants, pin bundles and state codes for the cpu board control block.
// assumes one 20 mhz master clock shared by the processor side and the memory bus.
package board_ctl_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned PF_GUARD_MS = 2;
    localparam int unsigned PF_GUARD_CYC = PF_GUARD_MS * (CLK_HZ / 1000);
    localparam int unsigned RAM_CYCLE_NS = 960;
    localparam int unsigned RMW_CYCLE_NS = 1920;
    localparam int unsigned RAM_CYC = RAM_CYCLE_NS / CLK_NS;
    localparam int unsigned RMW_CYC = RMW_CYCLE_NS / CLK_NS;
    localparam logic [4:0] IO_PAIRS = 5'h09;
    // ------------------------------------------------------------
    // addresses, words and register map
    // ------------------------------------------------------------
    localparam logic [14:0] JW_DEV_ADDR = 15'h7ffe;
    localparam logic [14:0] JW_START_ADDR = 15'h7fff;
    localparam logic [14:0] ROM_BASE = 15'h7fc0;
    localparam logic [7:0] JW_ADDR_FIXED = 8'h01;
    localparam logic [1:0] IO_HDR_BOOT = 2'h2;
    localparam logic [1:0] IO_HDR_RESTART = 2'h3;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CONT = 2;
    localparam int CTRL_BOOT = 3;
    localparam int CTRL_AUTO = 4;
    localparam logic AUTO_EN_RST = 1'b1;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic jw_enable;
        logic load_dev_sel;
        logic start_addr_sel;
        logic restart_inhibit;
        logic boot_rom_en;
        logic [2:0] bank_select;
        logic [5:0] device_code;
        logic [7:0] start_hi;
    } strap_t;
    typedef struct packed {
        logic lock;
        logic start;
        logic cont;
        logic stop;
        logic boot;
    } console_t;
    typedef struct packed {
        logic power_ok;
        logic power_fail;
        logic battery_ok;
        logic [1:0] io_req;
        console_t con;
        strap_t straps;
    } pins_t;
    typedef struct packed {
        logic addr_strobe;
        logic read_en;
        logic write_en;
        logic refresh;
    } mem_ctl_t;
    typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_RMW = 2'h2, OP_REFRESH = 2'h3} mem_op_t;
    typedef enum logic [4:0] {
        ST_DOWN = 5'h01, ST_HOLD = 5'h02, ST_RUN = 5'h04, ST_PFAIL = 5'h08, ST_TAKE = 5'h10
    } run_state_t;
    typedef enum logic [1:0] {SRC_BUS = 2'h0, SRC_JW = 2'h1, SRC_ROM = 2'h2, SRC_RAM = 2'h3} src_t;
    localparam run_state_t ST_RST = ST_DOWN;
endpackage : board_ctl_pkg

// File: logic/board_ctl.sv
// board_ctl: power-up hold, power-fail warning, run control, straps, restart and boot load.
// assumes pins and straps arrive asynchronously; processor-side memory requests share mclk.
// Contract
// - hold processor reset until power good, then run only on console, software or self-start; the code also runs a held processor on a power-fail warning
// - raise power-fail interrupt leaving at least 2 ms of running
// - jumper word supplies nothing unless its enable strap is fitted
// - load device strap makes the jumper word the boot device code
// - start address strap makes the jumper word the start and restart address unless the load device strap is also fitted
// - restart inhibit strap blocks auto-restart when battery power is absent
// - boot rom strap maps 64 rom words from 077700 to the top
// - auto-restart watches battery, lock and straps, takes over control on power return
// - boot load takes over control; processor runs rom copying bootstrap to 2-37
// - boot path is 16 bits wide, rom indexed by a 6-bit address
// - memory bus is 16-bit shared address/data, synchronous, four operation kinds
// - four control signals steer direction and timing on the shared lines
// - read, write, refresh take 960 ns, read-modify-write 1920 ns; the code takes 19 and 38 clocks, 950 and 1900 ns
// - on-board memory 2K or 4K words, 12-bit address, answers in its bank
// - io transfer is 2 bits per io clock: 2-bit header then 16 data bits
// - io bus carries a clear line plus request lines
// - non-overlapping processor clock phases from the master clock
// - console switches feed run control, boot address and restart monitor
// - with load device strap, address 077776 reads the device code word
// - with start address strap, address 077777 reads the start address word
// - fitted strap reads 1; six code bits, eight address bits, low byte fixed
// - three bank straps pick the 4K group of on-board memory
//
// Implementation choices: the plain strobed port and the address map.
module board_ctl
#(
    parameter int unsigned PF_GUARD = board_ctl_pkg::PF_GUARD_CYC,
    parameter int unsigned RAM_WORDS = 4096,
    parameter logic [15:0] DEFAULT_START = 16'h0000,
    parameter logic [1023:0] BOOT_IMAGE = '0
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire board_ctl_pkg::pins_t pins_async,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic cpu_reset,
    output logic cpu_run,
    output logic cpu_pf_irq,
    output logic start_pulse,
    output logic [15:0] start_pc,
    output logic takeover,
    output logic phase_a,
    output logic phase_b,
    input wire logic mem_req,
    input wire board_ctl_pkg::mem_op_t mem_op,
    input wire logic [14:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ready,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    output board_ctl_pkg::mem_ctl_t mem_ctl,
    output logic [15:0] mem_bus_out,
    output logic mem_bus_oe,
    input wire logic [15:0] mem_bus_in,
    output logic [1:0] io_data_p,
    output logic [1:0] io_data_n,
    output logic io_clk_p,
    output logic io_clk_n,
    output logic io_oe,
    output logic io_clr
);
    import board_ctl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        console_t cprev;
        strap_t sl;
        run_state_t st;
        logic pf_seen;
        logic auto_en;
        logic [15:0] pf_cnt;
        logic [1:0] ph;
        logic pa;
        logic pb;
        logic start_p;
        logic [15:0] pc;
        logic mbusy;
        logic mack;
        mem_op_t mop;
        logic [14:0] maddr;
        logic [15:0] mwdata;
        logic [5:0] mcnt;
        logic [15:0] mrdata;
        logic [15:0] bus_out;
        logic [17:0] io_sh;
        logic [4:0] io_cnt;
        logic io_ck;
        logic [15:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [15:0] ram [RAM_WORDS];
    logic pwr, pfw, go, halt, cont, boot, restart_ok, ram_we, last;
    logic [5:0] lim;
    src_t src;
    logic [15:0] rd_val;

    // jumper word as read back; a missing strap reads 0
    function automatic logic [15:0] jw_word(input strap_t s, input logic dev);
        jw_word = dev ? {10'h000, s.device_code} : {s.start_hi, JW_ADDR_FIXED};
    endfunction : jw_word

    // start address: jumper word only when enabled and selected
    function automatic logic [15:0] start_addr(input strap_t s);
        if (s.jw_enable && s.start_addr_sel && !s.load_dev_sel)
            start_addr = jw_word(s, 1'b0);
        else
            start_addr = DEFAULT_START;
    endfunction : start_addr

    // ------------------------------------------------------------
    // events from console, software and supply
    // ------------------------------------------------------------
    wire logic ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
    assign pwr = state_reg.s2.power_ok;
    assign pfw = state_reg.s2.power_fail;
    assign go = (state_reg.s2.con.start && !state_reg.cprev.start)
        || (ctrl_wr && reg_wdata[CTRL_START]);
    assign halt = (state_reg.s2.con.stop && !state_reg.cprev.stop)
        || (ctrl_wr && reg_wdata[CTRL_STOP]);
    assign cont = (state_reg.s2.con.cont && !state_reg.cprev.cont)
        || (ctrl_wr && reg_wdata[CTRL_CONT]);
    assign boot = (state_reg.s2.con.boot && !state_reg.cprev.boot)
        || (ctrl_wr && reg_wdata[CTRL_BOOT]);
    // battery-less restart is refused only when the inhibit strap is in
    assign restart_ok = state_reg.pf_seen && state_reg.auto_en && state_reg.s2.con.lock
        && !(state_reg.s2.straps.restart_inhibit && !state_reg.s2.battery_ok);

    // ------------------------------------------------------------
    // memory decode: jumper word beats rom, rom beats on-board ram
    // ------------------------------------------------------------
    always_comb
    begin
        if (state_reg.sl.jw_enable && state_reg.sl.load_dev_sel
            && state_reg.maddr == JW_DEV_ADDR)
            src = SRC_JW;
        else if (state_reg.sl.jw_enable && state_reg.sl.start_addr_sel
            && state_reg.maddr == JW_START_ADDR)
            src = SRC_JW;
        else if (state_reg.sl.boot_rom_en && state_reg.maddr >= ROM_BASE)
            src = SRC_ROM;
        else if (state_reg.maddr[14:12] == state_reg.sl.bank_select
            && 32'(state_reg.maddr[11:0]) < RAM_WORDS)
            src = SRC_RAM;
        else
            src = SRC_BUS;
    end

    assign lim = (state_reg.mop == OP_RMW) ? 6'(RMW_CYC) : 6'(RAM_CYC);
    assign last = state_reg.mbusy && state_reg.mcnt == lim - 6'h01;
    assign ram_we = last && src == SRC_RAM
        && (state_reg.mop == OP_WRITE || state_reg.mop == OP_RMW);

    // read value; rom index is the low six address bits
    always_comb
    begin
        case (src)
            SRC_JW: rd_val = jw_word(state_reg.sl, state_reg.maddr == JW_DEV_ADDR);
            SRC_ROM: rd_val = BOOT_IMAGE[{state_reg.maddr[5:0], 4'h0} +: 16];
            SRC_RAM: rd_val = ram[state_reg.maddr[11:0]];
            default: rd_val = mem_bus_in;
        endcase
    end

    // on-board ram; rmw returns the old word and stores the new one
    always_ff @(posedge mclk)
    begin
        if (ram_we)
            ram[state_reg.maddr[11:0]] <= state_reg.mwdata;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.s1 = pins_async;
        state_next.s2 = state_reg.s1;
        state_next.cprev = state_reg.s2.con;
        state_next.start_p = 1'b0;
        state_next.mack = 1'b0;
        state_next.rdata = 16'h0000;
        // four-step phase ring keeps a dead step between phases
        state_next.ph = state_reg.ph + 2'h1;
        state_next.pa = (state_next.ph == 2'h0);
        state_next.pb = (state_next.ph == 2'h2);
        // run control
        case (state_reg.st)
            ST_DOWN:
            begin
                state_next.sl = state_reg.s2.straps;
                state_next.pf_cnt = 16'h0000;
                if (pwr && !pfw)
                begin
                    state_next.pf_seen = 1'b0;
                    if (restart_ok)
                    begin
                        state_next.st = ST_TAKE;
                        state_next.pc = start_addr(state_reg.s2.straps);
                        state_next.start_p = 1'b1;
                        state_next.io_sh = {IO_HDR_RESTART, state_next.pc};
                        state_next.io_cnt = IO_PAIRS;
                        state_next.io_ck = 1'b0;
                    end
                    else
                        state_next.st = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (boot && state_reg.s2.straps.boot_rom_en)
                begin
                    state_next.sl = state_reg.s2.straps;
                    state_next.st = ST_TAKE;
                    state_next.pc = {1'b0, ROM_BASE};
                    state_next.start_p = 1'b1;
                    state_next.io_sh = {IO_HDR_BOOT, state_reg.s2.straps.jw_enable
                        ? jw_word(state_reg.s2.straps, 1'b1) : 16'h0000};
                    state_next.io_cnt = IO_PAIRS;
                    state_next.io_ck = 1'b0;
                end
                else if (go)
                begin
                    state_next.sl = state_reg.s2.straps;
                    state_next.pc = start_addr(state_reg.s2.straps);
                    state_next.start_p = 1'b1;
                    state_next.st = ST_RUN;
                end
                else if (cont)
                    state_next.st = ST_RUN;
            end
            ST_TAKE:
            begin
                if (state_reg.io_cnt == 5'h00)
                    state_next.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (halt)
                    state_next.st = ST_HOLD;
            end
            ST_PFAIL:
            begin
                // keep running through the guard time, then hold in reset
                state_next.pf_cnt = state_reg.pf_cnt + 16'h0001;
                if (state_reg.pf_cnt == 16'(PF_GUARD - 1))
                    state_next.st = ST_DOWN;
            end
            default: state_next.st = ST_DOWN;
        endcase
        if (pfw && state_reg.st != ST_DOWN && state_reg.st != ST_PFAIL)
        begin
            state_next.st = ST_PFAIL;
            state_next.pf_seen = 1'b1;
            state_next.pf_cnt = 16'h0000;
        end
        // a start launched in the cycle power drops must not leak out of reset
        if (!pwr)
        begin
            state_next.st = ST_DOWN;
            state_next.start_p = 1'b0;
        end
        // io frame: data set with clock low, held through clock high
        if (state_reg.io_cnt != 5'h00)
        begin
            state_next.io_ck = !state_reg.io_ck;
            if (state_reg.io_ck)
            begin
                state_next.io_sh = {state_reg.io_sh[15:0], 2'h0};
                state_next.io_cnt = state_reg.io_cnt - 5'h01;
            end
        end
        // memory cycle, one at a time
        if (!state_reg.mbusy)
        begin
            if (mem_req)
            begin
                state_next.mbusy = 1'b1;
                state_next.mcnt = 6'h00;
                state_next.mop = mem_op;
                state_next.maddr = mem_addr;
                state_next.mwdata = mem_wdata;
            end
        end
        else
        begin
            state_next.mcnt = state_reg.mcnt + 6'h01;
            if (last)
            begin
                state_next.mbusy = 1'b0;
                state_next.mack = 1'b1;
                state_next.mrdata = rd_val;
            end
        end
        state_next.bus_out = (state_next.mcnt == 6'h00) ? {1'b0, state_next.maddr}
            : state_next.mwdata;
        // software port
        if (ctrl_wr)
            state_next.auto_en = reg_wdata[CTRL_AUTO];
        if (reg_rd && reg_addr == REG_CTRL)
            state_next.rdata = {11'h000, state_reg.auto_en, 4'h0};
        else if (reg_rd && reg_addr == REG_STATUS)
            state_next.rdata = {3'h0, state_reg.s2.io_req, state_reg.pf_seen,
                state_reg.sl.jw_enable, state_reg.sl.load_dev_sel, state_reg.sl.start_addr_sel,
                state_reg.sl.restart_inhibit, state_reg.sl.boot_rom_en, state_reg.st};
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.st <= ST_RST;
            state_reg.auto_en <= AUTO_EN_RST;
        end
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = state_reg.rdata;
    assign cpu_reset = state_reg.st == ST_DOWN;
    assign cpu_run = state_reg.st == ST_RUN || state_reg.st == ST_PFAIL
        || state_reg.st == ST_TAKE;
    assign cpu_pf_irq = state_reg.st == ST_PFAIL;
    assign start_pulse = state_reg.start_p;
    assign start_pc = state_reg.pc;
    assign takeover = state_reg.st == ST_TAKE;
    assign phase_a = state_reg.pa;
    assign phase_b = state_reg.pb;
    assign mem_ready = !state_reg.mbusy;
    assign mem_ack = state_reg.mack;
    assign mem_rdata = state_reg.mrdata;
    // strobes follow the cycle count; rmw reads the first half, writes the second
    assign mem_ctl.addr_strobe = state_reg.mbusy && state_reg.mcnt == 6'h00;
    assign mem_ctl.read_en = state_reg.mbusy && state_reg.mcnt != 6'h00
        && (state_reg.mop == OP_READ
        || (state_reg.mop == OP_RMW && state_reg.mcnt < 6'(RAM_CYC)));
    assign mem_ctl.write_en = state_reg.mbusy && state_reg.mcnt != 6'h00
        && (state_reg.mop == OP_WRITE
        || (state_reg.mop == OP_RMW && state_reg.mcnt >= 6'(RAM_CYC)));
    assign mem_ctl.refresh = state_reg.mbusy && state_reg.mop == OP_REFRESH;
    assign mem_bus_out = state_reg.bus_out;
    assign mem_bus_oe = mem_ctl.addr_strobe || mem_ctl.write_en;
    assign io_data_p = state_reg.io_sh[17:16];
    assign io_data_n = ~state_reg.io_sh[17:16];
    assign io_clk_p = state_reg.io_ck;
    assign io_clk_n = !state_reg.io_ck;
    assign io_oe = state_reg.io_cnt != 5'h00;
    assign io_clr = state_reg.st == ST_DOWN;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_down_holds_reset:
        assert property (!pwr |=> cpu_reset && !cpu_run && !start_pulse)
        else $error("processor not held while power is bad");
    a_pf_irq_prompt:
        assert property (pwr && pfw && state_reg.st == ST_RUN |=> cpu_pf_irq)
        else $error("power-fail interrupt not raised");
    a_pf_guard_time:
        assert property (cpu_pf_irq && pwr && state_reg.pf_cnt < 16'(PF_GUARD - 1)
            |=> cpu_run || !$past(pwr))
        else $error("processor stopped inside the guard time");
    a_jw_needs_enable:
        assert property (last && !state_reg.sl.jw_enable && !state_reg.sl.boot_rom_en
            && state_reg.sl.bank_select != 3'h7 && state_reg.maddr == JW_DEV_ADDR
            |=> mem_rdata == $past(mem_bus_in))
        else $error("jumper word answered while disabled");
    a_dev_code_read:
        assert property (last && state_reg.sl.jw_enable && state_reg.sl.load_dev_sel
            && state_reg.maddr == JW_DEV_ADDR
            |=> mem_rdata == {10'h000, state_reg.sl.device_code})
        else $error("device code word wrong");
    a_start_word_read:
        assert property (last && state_reg.sl.jw_enable && state_reg.sl.start_addr_sel
            && state_reg.maddr == JW_START_ADDR
            |=> mem_rdata == {state_reg.sl.start_hi, JW_ADDR_FIXED})
        else $error("start address word wrong");
    a_restart_inhibit:
        assert property (state_reg.st == ST_DOWN && state_reg.s2.straps.restart_inhibit
            && !state_reg.s2.battery_ok |=> state_reg.st != ST_TAKE)
        else $error("auto-restart without battery");
    a_rom_in_window:
        assert property (last && src == SRC_ROM |-> state_reg.sl.boot_rom_en
            && state_reg.maddr >= ROM_BASE)
        else $error("rom answered outside its window");
    a_ram_cycle_time:
        assert property ($rose(state_reg.mbusy) && state_reg.mop != OP_RMW
            |-> !mem_ack [*8] ##12 mem_ack)
        else $error("memory cycle length wrong");
    a_rmw_cycle_time:
        assert property ($rose(state_reg.mbusy) && state_reg.mop == OP_RMW |-> ##38 mem_ack)
        else $error("read-modify-write length wrong");
    a_phases_apart:
        assert property (phase_a |=> !phase_a && !phase_b ##1 phase_b)
        else $error("clock phases overlap");
    a_io_frame_length:
        assert property ($rose(io_oe) |-> io_oe [*8] ##10 io_oe ##1 !io_oe)
        else $error("io frame length wrong");
endmodule : board_ctl

// File: verification/mem_far_end.sv
// mem_far_end: off-board memory on the far side of the board's shared memory bus.
// assumes the board's control lines and bus outputs change on the rising edge of mclk.
module mem_far_end
    import board_ctl_pkg::*;
(
    input wire logic mclk,
    input wire mem_ctl_t mem_ctl,
    input wire logic [15:0] mem_bus_out,
    output logic [15:0] mem_bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] addr_reg = 16'h0000;
    initial mem_bus_in = 16'h0000;
    // latch the address phase; off a read the lines keep flipping so stale data never matches
    always @(posedge mclk)
    begin
        if (mem_ctl.addr_strobe)
            addr_reg <= mem_bus_out;
        mem_bus_in <= mem_ctl.read_en ? (addr_reg ^ 16'ha5a5) : ~mem_bus_in;
    end
endmodule : mem_far_end

// File: verification/tb.sv
// tb: self-checking bench for board_ctl with an off-board memory model on its bus.
// assumes straps are changed only while power is held off or failing, as the board expects.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import board_ctl_pkg::*;
    typedef struct packed {mem_op_t op; strap_t s; logic [14:0] a; logic [15:0] w; logic [15:0] e;} row_t;
    localparam int PF = 20;
    logic mclk, reset, reg_wr, reg_rd, mem_req, mem_ack, cpu_reset, cpu_run, cpu_pf_irq;
    logic start_pulse, takeover, io_oe, io_clr, mem_ready, mem_bus_oe, io_clk_p;
    logic [3:0] reg_addr;
    logic [14:0] mem_addr;
    logic [15:0] reg_wdata, reg_rdata, start_pc, mem_wdata, mem_rdata, mem_bus_out, mem_bus_in;
    logic [1:0] io_data_p, io_data_n;
    pins_t pins;
    mem_op_t mem_op;
    mem_ctl_t mem_ctl;
    int bad_count = 0;
    int samples_checked = 0;
    // jumper word, rom, on-board ram and off-board reads; rmw gives back the old word
    row_t rows [9] = '{
        '{OP_READ, {5'b11000, 3'h0, 6'h2a, 8'h00}, 15'h7ffe, 16'h0000, 16'h002a},
        '{OP_READ, {5'b10100, 3'h0, 6'h00, 8'h5a}, 15'h7fff, 16'h0000, 16'h5a01},
        '{OP_READ, {5'b01000, 3'h0, 6'h2a, 8'h00}, 15'h7ffe, 16'h0000, 16'hda5b},
        '{OP_READ, {5'b00001, 3'h0, 6'h00, 8'h00}, 15'h7fc5, 16'h0000, 16'h1234},
        '{OP_WRITE, {5'b00000, 3'h2, 6'h00, 8'h00}, 15'h2005, 16'hbeef, 16'h0000},
        '{OP_RMW, {5'b00000, 3'h2, 6'h00, 8'h00}, 15'h2005, 16'h1357, 16'hbeef},
        '{OP_READ, {5'b00000, 3'h2, 6'h00, 8'h00}, 15'h2005, 16'h0000, 16'h1357},
        '{OP_READ, {5'b00000, 3'h2, 6'h00, 8'h00}, 15'h3005, 16'h0000, 16'h95a0},
        '{OP_REFRESH, {5'b00000, 3'h2, 6'h00, 8'h00}, 15'h0000, 16'h0000, 16'h0000}};

    board_ctl #(.PF_GUARD(PF), .BOOT_IMAGE({64{16'h1234}})) i_dut (
        .mclk(mclk), .reset(reset), .pins_async(pins), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_reset(cpu_reset), .cpu_run(cpu_run), .cpu_pf_irq(cpu_pf_irq),
        .start_pulse(start_pulse), .start_pc(start_pc), .takeover(takeover), .phase_a(),
        .phase_b(), .mem_req(mem_req), .mem_op(mem_op), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_ctl(mem_ctl), .mem_bus_out(mem_bus_out), .mem_bus_oe(mem_bus_oe),
        .mem_bus_in(mem_bus_in), .io_data_p(io_data_p), .io_data_n(io_data_n),
        .io_clk_p(io_clk_p), .io_clk_n(), .io_oe(io_oe), .io_clr(io_clr));
    mem_far_end i_far (.mclk(mclk), .mem_ctl(mem_ctl), .mem_bus_out(mem_bus_out),
        .mem_bus_in(mem_bus_in));

    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // straps are taken while held down or at a start or boot, so drop power around each change
    task automatic cfg(input strap_t s);
        pins.power_ok <= 1'b0;
        pins.straps <= s;
        repeat (6) @(posedge mclk);
        pins.power_ok <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask : cfg

    task automatic mem(input row_t r);
        int n;
        n = 1;
        mem_op <= r.op;
        mem_addr <= r.a;
        mem_wdata <= r.w;
        mem_req <= 1'b1;
        @(posedge mclk);
        mem_req <= 1'b0;
        // first busy cycle: not ready, address driven onto the bus
        @(negedge mclk);
        chk("mem_c1", {14'h0, mem_ready, mem_bus_oe}, 16'h0001);
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (mem_ack !== 1'b1 && n < 80);
        chk("mem_cycles", n[15:0], 16'(r.op == OP_RMW ? RMW_CYC + 1 : RAM_CYC + 1));
        if (r.op == OP_READ || r.op == OP_RMW)
            chk("mem_rdata", mem_rdata, r.e);
        chk("mem_ready", {15'h0, mem_ready}, 16'h0001);
        @(posedge mclk);
    endtask : mem

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
    endtask : rd

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // main sequence: reset, table rows, then start, power fail, restart and inhibit
    initial
    begin
        int n;
        logic [15:0] d;
        {reset, reg_wr, reg_rd, mem_req, reg_addr, reg_wdata} = {4'h8, 4'h0, 16'h0000};
        {mem_op, mem_addr, mem_wdata, pins} = '0;
        pins.power_ok = 1'b1;
        pins.con.lock = 1'b1;
        repeat (11) @(negedge mclk);
        chk("reset_hold", {13'h0, cpu_reset, cpu_run, io_clr}, 16'h0005);
        @(posedge mclk);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            cfg(rows[i].s);
            mem(rows[i]);
        end
        cfg({5'b10100, 3'h0, 6'h00, 8'h5a});
        // start, keeping auto-restart enabled
        {reg_addr, reg_wdata, reg_wr} <= {REG_CTRL, 16'h0011, 1'b1};
        @(posedge mclk);
        reg_wr <= 1'b0;
        for (n = 0; n < 10 && start_pulse !== 1'b1; n++)
            @(negedge mclk);
        chk("start_pulse", {15'h0, start_pulse}, 16'h0001);
        chk("start_pc", start_pc, 16'h5a01);
        @(negedge mclk);
        chk("cpu_run", {15'h0, cpu_run}, 16'h0001);
        @(posedge mclk);
        pins.power_fail <= 1'b1;
        for (n = 0; n < 10 && cpu_pf_irq !== 1'b1; n++)
            @(negedge mclk);
        @(posedge mclk);
        pins.power_fail <= 1'b0;
        for (n = 0; n < 99 && cpu_pf_irq === 1'b1; n++)
            @(negedge mclk);
        chk("pf_warning", n[15:0], 16'(PF));
        chk("pf_down", {15'h0, cpu_reset}, 16'h0001);
        for (n = 0; n < 10 && takeover !== 1'b1; n++)
            @(negedge mclk);
        chk("io_header", {10'h0, io_oe, io_clk_p, io_data_p, io_data_n},
            {10'h0, 2'b10, IO_HDR_RESTART, ~IO_HDR_RESTART});
        chk("restart_pc", start_pc, 16'h5a01);
        repeat (30) @(posedge mclk);
        pins.straps.restart_inhibit <= 1'b1;
        pins.power_fail <= 1'b1;
        repeat (40) @(posedge mclk);
        pins.power_fail <= 1'b0;
        repeat (10) @(posedge mclk);
        rd(REG_STATUS, d);
        chk("inhibit_state", d & 16'h001f, 16'h0002);
        rd(REG_CTRL, d);
        chk("auto_en", d & 16'h0010, 16'h0010);
        rd(4'h9, d);
        chk("unmapped", d, 16'h0000);
        summarize();
    end

    // cut a hang short far past the expected run length
    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        summarize();
    end
endmodule : tb
